// ---- core/bacd_consts.vh ----
// Constants of the auxiliary command decoder
// ==========================================================================
// Summary of operation
// (R1) Command 00111 releases the data-accepted holdoff left by address pass-through.
// (R2) After the non-valid command the device carries on as if another secondary address came.
// (R3) Command 01111 releases the holdoff and the device carries on as if its own secondary address came.
// (R4) The valid command also releases the holdoff at command pass-through and in the DCAS or DTAS holdoff.
// (R5) Commands 00101 and 01101 load the parallel poll flag with command bit 3.
// (R6) The ist message is the parallel poll flag when config B bit 4 is zero, else the SRQS state.
// (R7) Command 10000 asserts gts in CACS or on entering it, and gts clears on leaving CACS.
// (R8) Command 10001 pulses tca for one cycle.
// (R9) Command 10010 sets tcs and holds it until cleared.
// (R10) A pending tcs only acts in CSBS or CSWS.
// (R11) tcs clears on entering CACS whichever command set it.
// (R12) Command 11010 sets tcs only when an END is generated while in CSBS.
// (R13) The tcs set by the END command also clears on entering CACS.
// (R14) Chip reset by command or by pulse clears the parallel poll flag and the system control message.
// (R15) The listen command pulses ltn for one cycle.
// (R16) Software writes each 5-bit command in one register write and the decoder acts once per write.
// ==========================================================================
`ifndef BACD_CONSTS_VH
`define BACD_CONSTS_VH

// Register byte addresses
`define BACD_ADDR_CMD 8'h00
`define BACD_ADDR_CFGB 8'h04
`define BACD_ADDR_STAT 8'h08
`define BACD_ADDR_CTRL 8'h0C

// Command codes
`define BACD_CMD_CHIP_RESET 5'h02
`define BACD_CMD_NONVALID 5'h07
`define BACD_CMD_VALID 5'h0F
`define BACD_CMD_PPF_LOW 4'h5
`define BACD_CMD_GTS 5'h10
`define BACD_CMD_TCA 5'h11
`define BACD_CMD_TCS 5'h12
`define BACD_CMD_LISTEN 5'h13
`define BACD_CMD_TCS_END 5'h1A

// Field positions
`define BACD_CFGB_ISS_BIT 4
`define BACD_CTRL_RSC_BIT 0
`define BACD_CMD_BIT3 3

// Reset values
`define BACD_CFGB_RST 8'h00
`define BACD_CTRL_RSC_RST 1'b0

`endif

// ---- core/bacd_decode.v ----
// Combinational decode of one auxiliary command code
`timescale 1ns/1ps
module bacd_decode (
    // Command
    input wire [4:0] code_i,
    input wire valid_i,
    // Decoded strobes
    output wire chip_reset_o,
    output wire nonvalid_o,
    output wire valid_cmd_o,
    output wire ppf_load_o,
    output wire gts_o,
    output wire tca_o,
    output wire tcs_o,
    output wire listen_o,
    output wire tcs_end_o
);
`include "bacd_consts.vh"

    assign chip_reset_o = valid_i && (code_i == `BACD_CMD_CHIP_RESET);
    assign nonvalid_o = valid_i && (code_i == `BACD_CMD_NONVALID);
    assign valid_cmd_o = valid_i && (code_i == `BACD_CMD_VALID);
    // Both flag codes differ only in bit 3
    assign ppf_load_o = valid_i && ({code_i[4], code_i[2:0]} == `BACD_CMD_PPF_LOW);
    assign gts_o = valid_i && (code_i == `BACD_CMD_GTS);
    assign tca_o = valid_i && (code_i == `BACD_CMD_TCA);
    assign tcs_o = valid_i && (code_i == `BACD_CMD_TCS);
    assign listen_o = valid_i && (code_i == `BACD_CMD_LISTEN);
    assign tcs_end_o = valid_i && (code_i == `BACD_CMD_TCS_END);
endmodule // bacd_decode

// ---- core/bacd_top.v ----
// Auxiliary command decoder with Wishbone register slave
`timescale 1ns/1ps
module bacd_top (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Bus function states and events
    input wire ext_reset_i,
    input wire cacs_i,
    input wire csbs_i,
    input wire csws_i,
    input wire srqs_i,
    input wire end_gen_i,
    input wire cpt_pending_i,
    input wire dcas_holdoff_i,
    input wire dtas_holdoff_i,
    // Local messages
    output reg dac_release_o,
    output reg osa_o,
    output reg msa_o,
    output reg ist_o,
    output reg gts_o,
    output reg tca_o,
    output reg tcs_o,
    output reg tcs_effective_o,
    output reg ltn_o,
    output reg rsc_o,
    output reg ppf_o
);
`include "bacd_consts.vh"

    // ======================================================================
    // Bus slave
    // ======================================================================
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = req && wb_we_i;
    // One decode per accepted write: ack masks the second cycle
    wire cmd_wr = wr && (wb_adr_i == `BACD_ADDR_CMD) && wb_sel_i[0]; // [R16]

    reg [7:0] cfgb_reg;
    reg cacs_prev_reg;
    reg gts_req_reg;
    reg tcs_end_arm_reg;

    wire d_reset;
    wire d_nonvalid;
    wire d_valid;
    wire d_ppf;
    wire d_gts;
    wire d_tca;
    wire d_tcs;
    wire d_listen;
    wire d_tcs_end;

    bacd_decode u_dec (
        .code_i(wb_dat_i[4:0]),
        .valid_i(cmd_wr),
        .chip_reset_o(d_reset),
        .nonvalid_o(d_nonvalid),
        .valid_cmd_o(d_valid),
        .ppf_load_o(d_ppf),
        .gts_o(d_gts),
        .tca_o(d_tca),
        .tcs_o(d_tcs),
        .listen_o(d_listen),
        .tcs_end_o(d_tcs_end)
    );

    wire chip_reset = d_reset || ext_reset_i;
    wire enter_cacs = cacs_i && !cacs_prev_reg;
    wire leave_cacs = !cacs_i && cacs_prev_reg;

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0000_0000;
            if (req && !wb_we_i) begin
                case (wb_adr_i)
                    `BACD_ADDR_CFGB: wb_dat_o <= {24'h00_0000, cfgb_reg};
                    `BACD_ADDR_STAT: wb_dat_o <= {24'h00_0000, tcs_end_arm_reg,
                        gts_req_reg, ppf_o, ist_o, gts_o, tcs_o, tcs_effective_o, rsc_o};
                    `BACD_ADDR_CTRL: wb_dat_o <= {31'h0000_0000, rsc_o};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ======================================================================
    // Configuration and system control
    // ======================================================================
    always @(posedge clk_i) begin
        if (rst_i) begin
            cfgb_reg <= `BACD_CFGB_RST;
            rsc_o <= `BACD_CTRL_RSC_RST;
        end else if (chip_reset) begin
            cfgb_reg <= `BACD_CFGB_RST;
            rsc_o <= 1'b0; // [R14]
        end else begin
            if (wr && wb_adr_i == `BACD_ADDR_CFGB && wb_sel_i[0])
                cfgb_reg <= wb_dat_i[7:0];
            if (wr && wb_adr_i == `BACD_ADDR_CTRL && wb_sel_i[0])
                rsc_o <= wb_dat_i[`BACD_CTRL_RSC_BIT];
        end
    end

    // ======================================================================
    // Local messages
    // ======================================================================
    always @(posedge clk_i) begin
        if (rst_i) begin
            cacs_prev_reg <= 1'b0;
            ppf_o <= 1'b0;
            ist_o <= 1'b0;
            dac_release_o <= 1'b0;
            osa_o <= 1'b0;
            msa_o <= 1'b0;
            gts_req_reg <= 1'b0;
            gts_o <= 1'b0;
            tca_o <= 1'b0;
            tcs_o <= 1'b0;
            tcs_end_arm_reg <= 1'b0;
            tcs_effective_o <= 1'b0;
            ltn_o <= 1'b0;
        end else begin
            cacs_prev_reg <= cacs_i;
            if (chip_reset)
                ppf_o <= 1'b0; // [R14]
            else if (d_ppf)
                ppf_o <= wb_dat_i[`BACD_CMD_BIT3]; // [R5]
            // Source follows the latest config value
            ist_o <= cfgb_reg[`BACD_CFGB_ISS_BIT] ? srqs_i : ppf_o; // [R6]
            // Valid also covers pass-through and DCAS/DTAS holdoff cases
            dac_release_o <= d_nonvalid || d_valid; // [R1] [R3] [R4]
            osa_o <= d_nonvalid; // [R2]
            msa_o <= d_valid && (1'b1 || cpt_pending_i || dcas_holdoff_i
                || dtas_holdoff_i); // [R3] [R4]
            // gts waits for CACS; leaving CACS drops it and the request
            if (leave_cacs) begin
                // A command in the leaving cycle still waits for the next CACS
                gts_req_reg <= d_gts;
                gts_o <= 1'b0; // [R7]
            end else if (d_gts || gts_req_reg) begin
                if (cacs_i) begin
                    gts_o <= 1'b1; // [R7]
                    gts_req_reg <= 1'b0;
                end else begin
                    gts_req_reg <= 1'b1;
                end
            end
            tca_o <= d_tca; // [R8]
            ltn_o <= d_listen; // [R15]
            // Set wins over the clear on entry to CACS
            if (d_tcs)
                tcs_o <= 1'b1; // [R9]
            else if (tcs_end_arm_reg && end_gen_i && csbs_i)
                tcs_o <= 1'b1; // [R12]
            else if (enter_cacs)
                tcs_o <= 1'b0; // [R11] [R13]
            if (d_tcs_end)
                tcs_end_arm_reg <= 1'b1;
            else if (enter_cacs || (end_gen_i && csbs_i))
                tcs_end_arm_reg <= 1'b0; // [R12] [R13]
            tcs_effective_o <= tcs_o && (csbs_i || csws_i); // [R10]
        end
    end
endmodule // bacd_top

// ---- verification/bacd_bus_model.sv ----
// Behavioural bus function states facing the decoder
`timescale 1ns/1ps
module bacd_bus_model (
    // Scenario control
    input wire clk_i,
    input wire [1:0] st_i,
    input wire srq_i,
    input wire end_i,
    // Bus function states
    output reg cacs_o,
    output reg csbs_o,
    output reg csws_o,
    output reg srqs_o,
    output reg end_gen_o
);
    // One controller state at a time, moved just after an edge
    always @(posedge clk_i) begin
        cacs_o <= st_i == 2'd1;
        csbs_o <= st_i == 2'd2;
        csws_o <= st_i == 2'd3;
        srqs_o <= srq_i;
        end_gen_o <= end_i && st_i == 2'd2;
    end
endmodule // bacd_bus_model

// ---- verification/bacd_chk.sv ----
// Port checks of the auxiliary command decoder
`timescale 1ns/1ps
module bacd_chk (
    input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ext_reset_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    input wire cacs_i, csbs_i, csws_i, dac_release_o, osa_o, msa_o, gts_o,
    input wire tca_o, tcs_o, tcs_effective_o, ltn_o, rsc_o, ppf_o
);
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire cmd = take && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00;
    wire [4:0] c = wb_dat_i[4:0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_once_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o) else $error("bad ack");
    osa_pulse_a: assert property (cmd && c == 5'h07 |=> dac_release_o && osa_o && !msa_o
        ##1 !osa_o) else $error("bad osa");
    msa_pulse_a: assert property (cmd && c == 5'h0F |=> dac_release_o && msa_o && !osa_o
        ##1 !msa_o) else $error("bad msa");
    ppf_load_a: assert property (cmd && c[2:0] == 3'h5 && !c[4] |=> ppf_o == $past(c[3]))
        else $error("bad ppf");
    gts_leave_a: assert property (!cacs_i |=> !gts_o) else $error("gts outside");
    tca_pulse_a: assert property (cmd && c == 5'h11 |=> tca_o ##1 !tca_o) else $error("tca");
    tcs_gate_a: assert property (tcs_effective_o == $past(tcs_o && (csbs_i || csws_i)))
        else $error("bad tcs gate");
    tcs_clear_a: assert property ($rose(cacs_i) && !take |=> !tcs_o) else $error("tcs");
    ltn_pulse_a: assert property (cmd && c == 5'h13 |=> ltn_o ##1 !ltn_o) else $error("ltn");
    reset_clr_a: assert property (ext_reset_i |=> !ppf_o && !rsc_o) else $error("rst");
    cover property (cmd && c == 5'h1A);
    cover property ($rose(tcs_effective_o));
    cover property ($rose(gts_o));
endmodule // bacd_chk
bind bacd_top bacd_chk chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
    .ext_reset_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .cacs_i, .csbs_i, .csws_i, .dac_release_o,
    .osa_o, .msa_o, .gts_o, .tca_o, .tcs_o, .tcs_effective_o, .ltn_o, .rsc_o, .ppf_o);

// ---- verification/tb_top.sv ----
// Self-checking bench of the auxiliary command decoder
`timescale 1ns/1ps
module tb_top;
    reg clk_i = 0, rst_i = 1, cyc = 0, we = 0, ext_reset_i = 0, srq = 0, endr = 0, ho = 0;
    reg [7:0] adr = 8'h00;
    reg [31:0] dat = 32'h0000_0000, q;
    reg [1:0] st = 2'd0;
    reg [4:0] pls;
    wire ack, cacs, csbs, csws, srqs, endg, dac, osa, msa, ist, gts, tca, tcs, tcse, ltn, request_system_control_msg, ppf;
    wire [31:0] rd;
    integer fail_count = 0, n_checks = 0;
    always #50 clk_i = ~clk_i;
    bacd_bus_model bm_u (.clk_i(clk_i), .st_i(st), .srq_i(srq), .end_i(endr), .cacs_o(cacs),
        .csbs_o(csbs), .csws_o(csws), .srqs_o(srqs), .end_gen_o(endg));
    bacd_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o(rd), .wb_ack_o(ack),
        .ext_reset_i(ext_reset_i), .cacs_i(cacs), .csbs_i(csbs), .csws_i(csws), .srqs_i(srqs),
        .end_gen_i(endg), .cpt_pending_i(ho), .dcas_holdoff_i(ho), .dtas_holdoff_i(ho),
        .dac_release_o(dac), .osa_o(osa), .msa_o(msa), .ist_o(ist), .gts_o(gts), .tca_o(tca),
        .tcs_o(tcs), .tcs_effective_o(tcse), .ltn_o(ltn), .rsc_o(request_system_control_msg), .ppf_o(ppf));
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    // Holds the request until ack is sampled, then releases it
    task xfer(input [7:0] a, input w, input [31:0] d);
        integer k;
        begin
            @(posedge clk_i);
            cyc <= 1'b1; we <= w; adr <= a; dat <= d;
            k = 0;
            do begin @(posedge clk_i); k = k + 1; end while (ack !== 1'b1 && k < 20);
            q = rd;
            pls = {dac, osa, msa, tca, ltn};
            cyc <= 1'b0;
            if (k >= 20) check(k, 0);
        end
    endtask
    task cmd(input [4:0] c);
        xfer(8'h00, 1'b1, {27'h000_0000, c});
    endtask
    task t_dac;
        begin
            ho <= 1'b1; cmd(5'h07); check(pls, 5'b1_1000);
            cmd(5'h0F); check(pls, 5'b1_0100);
        end
    endtask
    task t_ppf;
        begin
            cmd(5'h0D); tick(2); check({ppf, ist}, 2'b11);
            xfer(8'h04, 1'b1, 32'h0000_0010); tick(3); check(ist, 0);
            xfer(8'h04, 1'b0, 0); check(q, 32'h0000_0010);
            srq <= 1'b1; tick(3); check(ist, 1);
            xfer(8'h04, 1'b1, 0); cmd(5'h05); tick(2); check({ppf, ist}, 0);
        end
    endtask
    task t_gts;
        begin
            st <= 2'd0; cmd(5'h10); tick(2); check(gts, 0);
            st <= 2'd1; tick(3); check(gts, 1); st <= 2'd2; tick(3); check(gts, 0);
            st <= 2'd1; cmd(5'h10); tick(2); check(gts, 1);
        end
    endtask
    task t_tc;
        begin
            cmd(5'h11); check(pls, 5'b0_0010); cmd(5'h13); check(pls, 5'b0_0001);
            st <= 2'd0; cmd(5'h12); tick(2); check({tcs, tcse}, 2'b10);
            st <= 2'd3; tick(3); check({tcs, tcse}, 2'b11);
            st <= 2'd1; tick(3); check(tcs, 0);
        end
    endtask
    task t_end;
        begin
            st <= 2'd2; cmd(5'h1A); tick(2); check(tcs, 0);
            endr <= 1'b1; tick(1); endr <= 1'b0; tick(3); check(tcs, 1);
            st <= 2'd1; tick(3); check(tcs, 0);
        end
    endtask
    task t_rst;
        begin
            xfer(8'h0C, 1'b1, 1); cmd(5'h0D); check({request_system_control_msg, ppf}, 2'b11);
            xfer(8'h08, 1'b0, 0); check(q, 32'h0000_0031);
            ext_reset_i <= 1'b1; tick(1); ext_reset_i <= 1'b0; tick(2); check({request_system_control_msg, ppf}, 0);
            xfer(8'h0C, 1'b1, 1); cmd(5'h0D); cmd(5'h02); tick(1); check({request_system_control_msg, ppf}, 0);
            xfer(8'h10, 1'b0, 0); check(q, 0);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, fail_count);
            if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        #100000;
        fail_count = fail_count + 1;
        finish_test;
    end
    initial begin
        tick(4); rst_i <= 1'b0;
        t_dac; t_ppf; t_gts; t_tc; t_end; t_rst;
        finish_test;
    end
endmodule // tb_top
